// >>> sms_pkg.sv
package sms_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Register offsets
    localparam logic [ADDR_W-1:0] NET_CTRL_OFS   = 12'h000;
    localparam logic [ADDR_W-1:0] INT_STATUS_OFS = 12'h004;
    localparam logic [ADDR_W-1:0] INT_MASK_OFS   = 12'h008;
    localparam logic [ADDR_W-1:0] CNT_BASE_OFS   = 12'h100;
    localparam logic [ADDR_W-1:0] OCT_RX_LO_OFS  = 12'h180;
    localparam logic [ADDR_W-1:0] OCT_RX_HI_OFS  = 12'h184;
    localparam logic [ADDR_W-1:0] LPI_TIME_OFS   = 12'h274;
    localparam int                CNT_WIN_LSB    = 7;

    // Control register fields and reset value
    localparam int                RECEIVE_ON_BIT = 2;
    localparam int                LPI_ON_BIT     = 19;
    localparam logic [DATA_W-1:0] NET_CTRL_RST   = 32'h0000_0000;

    // Interrupt status and mask layout
    localparam int              INT_N       = 2;
    localparam int              INT_OVF_BIT = 0;
    localparam int              INT_SAT_BIT = 1;
    localparam logic [INT_N-1:0] INT_RST    = 2'h0;

    // Counter bank: transmit entries first, then receive entries
    localparam int TX_N  = 12;
    localparam int RX_N  = 15;
    localparam int CNT_N = TX_N + RX_N;
    localparam int IDX_W = 5;

    localparam int TX_128_255    = 0;
    localparam int TX_256_511    = 1;
    localparam int TX_512_1023   = 2;
    localparam int TX_1024_1518  = 3;
    localparam int TX_OVER_1518  = 4;
    localparam int TX_UNDERRUN   = 5;
    localparam int TX_SINGLE_COL = 6;
    localparam int TX_MULTI_COL  = 7;
    localparam int TX_EXCESS_COL = 8;
    localparam int TX_LATE_COL   = 9;
    localparam int TX_DEFERRED   = 10;
    localparam int TX_CARRIER    = 11;
    localparam int RX_1024_1518  = 0;
    localparam int RX_1519_MAX   = 1;
    localparam int RX_UNDERSIZE  = 2;
    localparam int RX_OVERSIZE   = 3;
    localparam int RX_JABBER     = 4;
    localparam int RX_FCS_ERR    = 5;
    localparam int RX_LENGTH_ERR = 6;
    localparam int RX_SYMBOL_ERR = 7;
    localparam int RX_ALIGN_ERR  = 8;
    localparam int RX_RESOURCE   = 9;
    localparam int RX_OVERRUN    = 10;
    localparam int RX_IP_CSUM    = 11;
    localparam int RX_TCP_CSUM   = 12;
    localparam int RX_UDP_CSUM   = 13;
    localparam int RX_FRAMES     = 14;

    localparam int OCT_W   = 48;
    localparam int BYTES_W = 14;

    // Idle time tick: one count per this many clock cycles
    localparam int LPI_DIV   = 16;
    localparam int LPI_DIV_W = 4;
    localparam int LPI_W     = 24;

    typedef struct packed {
        logic [TX_N-1:0]    tx;
        logic [RX_N-1:0]    rx;
        logic [BYTES_W-1:0] rx_bytes;
    } sms_evt_s;

endpackage

// >>> sms_stat_bank.sv
`timescale 1ns/1ps
// Summary of operation
// - A read returns the counter value and clears that counter.
// - Counters stop at all ones instead of wrapping.
// - Receive counters advance only while the receive-on bit is set.
// - Received octets form one 48-bit count over two registers.
// - Idle time counts once per 16 clocks while idle enable is set.
// - Idle time sits in bits 23:0, upper bits zero, clear on read.
// - Transmit size bins 128-255 to 1024-1518 plus over 1518 bytes.
// - Receive bins 1024-1518 and 1519 up to maximum length.
// - Single, multiple, excessive and late collisions counted separately.
// - Underruns, deferred frames and carrier sense errors counted.
// - Undersize, oversize, jabber, FCS, length, symbol, alignment errors.
// - Resource errors, overruns, IP, TCP and UDP checksum errors.
// - Total received frames has its own counter.
// - A frame ending while the buffer is full is dropped and counted.
module sms_stat_bank
    import sms_pkg::*;
#(
    parameter int CNT_W = 32
) (
    input  wire logic              mclk_in,
    input  wire logic              resetn_in,
    input  wire logic              ce_in,
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [ADDR_W-1:0] paddr_in,
    input  wire logic [DATA_W-1:0] pwdata_in,
    output logic      [DATA_W-1:0] prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    input  wire sms_evt_s          evt_in,
    input  wire logic              rx_buf_full_in,
    output logic                   rx_drop_out,
    output logic                   irq_out
);

    logic [DATA_W-1:0] network_control_reg;
    logic [INT_N-1:0]  int_status;
    logic [INT_N-1:0]  int_mask;
    logic [CNT_W-1:0]  cnt [CNT_N];
    logic [OCT_W-1:0]  oct_rx;
    logic [OCT_W-1:0]  oct_snap;
    logic [LPI_W-1:0]  lpi_rx_time_count;
    logic [LPI_DIV_W-1:0] lpi_div;

    // Bus phases: one wait state lets read data come from a flop
    wire prep_cyc = psel_in & penable_in & ~pready_out;
    wire done_cyc = psel_in & penable_in & pready_out;
    wire rd_done  = done_cyc & ~pwrite_in;
    wire wr_done  = done_cyc & pwrite_in;

    // Address decode
    wire             ncr_hit    = paddr_in == NET_CTRL_OFS;
    wire             stat_hit   = paddr_in == INT_STATUS_OFS;
    wire             mask_hit   = paddr_in == INT_MASK_OFS;
    wire             oct_lo_hit = paddr_in == OCT_RX_LO_OFS;
    wire             oct_hi_hit = paddr_in == OCT_RX_HI_OFS;
    wire             lpi_hit    = paddr_in == LPI_TIME_OFS;
    wire [IDX_W-1:0] cnt_idx    = paddr_in[CNT_WIN_LSB-1:2];
    wire             cnt_hit    = (paddr_in[ADDR_W-1:CNT_WIN_LSB]
                                   == CNT_BASE_OFS[ADDR_W-1:CNT_WIN_LSB])
                                  && (paddr_in[1:0] == 2'h0)
                                  && (cnt_idx < IDX_W'(CNT_N));
    wire             any_hit    = ncr_hit | stat_hit | mask_hit | oct_lo_hit
                                  | oct_hi_hit | lpi_hit | cnt_hit;

    wire [DATA_W-1:0] rd_word =
        ncr_hit    ? network_control_reg :
        stat_hit   ? DATA_W'(int_status) :
        mask_hit   ? DATA_W'(int_mask) :
        oct_lo_hit ? oct_rx[DATA_W-1:0] :
        oct_hi_hit ? DATA_W'(oct_snap[OCT_W-1:DATA_W]) :
        lpi_hit    ? DATA_W'(lpi_rx_time_count) :
        cnt_hit    ? DATA_W'(cnt[cnt_idx]) :
                     32'h0000_0000;

    wire receive_on_bit    = network_control_reg[RECEIVE_ON_BIT];
    wire low_power_idle_on = network_control_reg[LPI_ON_BIT];

    // A frame that ends into a full buffer is dropped and counts as overrun
    wire ovf_evt   = evt_in.rx[RX_FRAMES] & rx_buf_full_in;
    wire [RX_N-1:0] rx_raw = evt_in.rx | (RX_N'(ovf_evt) << RX_OVERRUN);
    wire [RX_N-1:0] rx_inc = receive_on_bit ? rx_raw : '0;
    wire [CNT_N-1:0] inc   = {rx_inc, evt_in.tx};

    // Counter bank; clearing subtracts the value already returned
    wire [CNT_N-1:0] sat_flag;
    wire [CNT_W-1:0] next_cnt [CNT_N];
    genvar gi;
    generate
        for (gi = 0; gi < CNT_N; gi++) begin : g_cnt
            wire             rd_clr = rd_done & cnt_hit & (cnt_idx == IDX_W'(gi));
            // Subtracting keeps an event that landed after capture
            wire [CNT_W-1:0] base   = rd_clr ? cnt[gi] - prdata_out[CNT_W-1:0]
                                             : cnt[gi];
            assign next_cnt[gi] = (inc[gi] & ~&base) ? base + 1'b1 : base;
            assign sat_flag[gi] = &cnt[gi];
            always_ff @(posedge mclk_in) begin
                if (!resetn_in) begin
                    cnt[gi] <= '0;
                end else if (ce_in) begin
                    cnt[gi] <= next_cnt[gi];
                end
            end
        end
    endgenerate

    // Received octets, 48 bits wide; high 16 bits read from the snapshot
    wire             oct_clr  = rd_done & oct_lo_hit;
    wire [OCT_W-1:0] oct_base = oct_clr ? oct_rx - oct_snap : oct_rx;
    wire [OCT_W:0]   oct_sum  = {1'b0, oct_base}
                                + (OCT_W+1)'(rx_inc[RX_FRAMES] ? evt_in.rx_bytes : '0);
    wire [OCT_W-1:0] next_oct = oct_sum[OCT_W] ? '1 : oct_sum[OCT_W-1:0];

    // Idle time prescaler and count
    wire             lpi_tick  = low_power_idle_on && (lpi_div == LPI_DIV_W'(LPI_DIV - 1));
    wire             lpi_clr   = rd_done & lpi_hit;
    wire [LPI_W-1:0] lpi_base  = lpi_clr ? lpi_rx_time_count - prdata_out[LPI_W-1:0]
                                         : lpi_rx_time_count;
    wire [LPI_W-1:0] next_lpi  = (lpi_tick & ~&lpi_base) ? lpi_base + 1'b1 : lpi_base;

    wire any_sat = (|sat_flag) | (&oct_rx) | (&lpi_rx_time_count);
    wire [INT_N-1:0] int_set = (INT_N'(ovf_evt) << INT_OVF_BIT)
                               | (INT_N'(any_sat) << INT_SAT_BIT);
    wire [INT_N-1:0] int_clr = (wr_done & stat_hit) ? pwdata_in[INT_N-1:0] : '0;
    // Set beats a same-cycle clear
    wire [INT_N-1:0] next_int_status = (int_status & ~int_clr) | int_set;

    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            oct_rx            <= '0;
            oct_snap          <= '0;
            lpi_rx_time_count <= '0;
            lpi_div           <= '0;
        end else if (ce_in) begin
            oct_rx            <= next_oct;
            lpi_rx_time_count <= next_lpi;
            // Divider restarts when idle is switched off
            lpi_div           <= low_power_idle_on ? lpi_div + 1'b1 : '0;
            if (prep_cyc & ~pwrite_in & oct_lo_hit) begin
                oct_snap <= oct_rx;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            network_control_reg <= NET_CTRL_RST;
            int_status          <= INT_RST;
            int_mask            <= INT_RST;
        end else if (ce_in) begin
            int_status <= next_int_status;
            if (wr_done & ncr_hit) begin
                network_control_reg <= pwdata_in;
            end
            if (wr_done & mask_hit) begin
                int_mask <= pwdata_in[INT_N-1:0];
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            prdata_out  <= '0;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            rx_drop_out <= 1'b0;
            irq_out     <= 1'b0;
        end else if (ce_in) begin
            pready_out  <= prep_cyc;
            pslverr_out <= prep_cyc & ~any_hit;
            if (prep_cyc) begin
                prdata_out <= pwrite_in ? '0 : rd_word;
            end
            rx_drop_out <= ovf_evt;
            irq_out     <= |(next_int_status & int_mask);
        end
    end

endmodule

// >>> sms_stat_bank_props.sv
`timescale 1ns/1ps
module sms_stat_bank_props
    import sms_pkg::*;
#(
    parameter int CNT_W = 32
) (
    input wire logic              mclk_in,
    input wire logic              resetn_in,
    input wire logic              ce_in,
    input wire logic              psel_in,
    input wire logic              penable_in,
    input wire logic              pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [DATA_W-1:0] pwdata_in,
    input wire logic [DATA_W-1:0] prdata_out,
    input wire logic              pready_out,
    input wire logic              pslverr_out,
    input wire sms_evt_s          evt_in,
    input wire logic              rx_buf_full_in,
    input wire logic              rx_drop_out,
    input wire logic              irq_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_wait; psel_in && penable_in && !pready_out; endsequence
    sequence s_drop; evt_in.rx[RX_FRAMES] && rx_buf_full_in; endsequence
    sequence s_rd(a); pready_out && !pwrite_in && paddr_in == a; endsequence
    property p_ready_wait; s_wait |=> pready_out; endproperty
    property p_ready_pulse; pready_out |=> !pready_out; endproperty
    property p_err_ready; pslverr_out |-> pready_out; endproperty
    property p_wr_zero; pready_out && pwrite_in |-> prdata_out == 32'h0; endproperty
    property p_lpi_upper; s_rd(LPI_TIME_OFS) |-> prdata_out[31:24] == 8'h00; endproperty
    property p_oct_hi; s_rd(OCT_RX_HI_OFS) |-> prdata_out[31:16] == 16'h0000; endproperty
    property p_drop; s_drop |=> rx_drop_out; endproperty
    property p_drop_cause; rx_drop_out |-> $past(evt_in.rx[RX_FRAMES] && rx_buf_full_in); endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("ready late");
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    a_wr_zero: assert property (p_wr_zero) else $error("write data nonzero");
    a_lpi_upper: assert property (p_lpi_upper) else $error("idle upper bits set");
    a_oct_hi: assert property (p_oct_hi) else $error("octet high too wide");
    a_drop: assert property (p_drop) else $error("drop missing");
    a_drop_cause: assert property (p_drop_cause) else $error("drop without cause");
endmodule

bind sms_stat_bank sms_stat_bank_props #(.CNT_W(CNT_W)) u_props (.mclk_in(mclk_in),
    .resetn_in(resetn_in), .ce_in(ce_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .evt_in(evt_in), .rx_buf_full_in(rx_buf_full_in), .rx_drop_out(rx_drop_out),
    .irq_out(irq_out));

// >>> sms_stat_bank_tb.sv
`timescale 1ns/1ps
module sms_stat_bank_tb;
    import sms_pkg::*;
    // Narrow counters so saturation is reached in a few events
    localparam int CW = 4;
    logic              mclk_in = 0, resetn_in = 0, psel = 0, pen = 0, pwr = 0, full = 0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata, rd;
    logic              pready, pslverr, err, drop, irq, rxon = 0;
    sms_evt_s          evt = '0;
    int                bad_count = 0, tests_run = 0, k, oct = 0;
    sms_stat_bank #(.CNT_W(CW)) dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .ce_in(1'b1),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .evt_in(evt), .rx_buf_full_in(full), .rx_drop_out(drop), .irq_out(irq));
    initial forever #4 mclk_in = ~mclk_in;
    function automatic logic [ADDR_W-1:0] ca(int i);
        return CNT_BASE_OFS + ADDR_W'(4 * i);
    endfunction
    function automatic logic [DATA_W-1:0] sat(int n);
        return (n > 2**CW - 1) ? DATA_W'(2**CW - 1) : DATA_W'(n);
    endfunction
    task automatic chk(string n, logic [DATA_W-1:0] seen, logic [DATA_W-1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic apb(logic w, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_in);
        pen <= 1'b1;
        do @(posedge mclk_in); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        // Idle cycle keeps the next setup from rewriting psel in this step
        @(posedge mclk_in);
    endtask
    // Strobes are spaced so the clearing assignment never meets the next set
    task automatic pulse(logic tx, int idx, int n);
        logic [BYTES_W-1:0] b;
        repeat (n) begin
            b = BYTES_W'($urandom_range(1518, 64));
            if (tx) evt.tx[idx] <= 1'b1;
            else evt.rx[idx] <= 1'b1;
            evt.rx_bytes <= b;
            if (!tx && idx == RX_FRAMES && rxon && !full) oct += int'(b);
            @(posedge mclk_in);
            evt <= '0;
            @(posedge mclk_in);
        end
    endtask
    initial begin
        void'($urandom(29));
        repeat (10) @(posedge mclk_in);
        resetn_in <= 1'b1;
        @(posedge mclk_in);
        apb(0, LPI_TIME_OFS, 0);
        chk("idle time reset", rd, 0);
        apb(0, 12'hFFC, 0);
        chk("unmapped error", DATA_W'(err), 1);
        pulse(0, RX_FCS_ERR, 3);
        apb(0, ca(TX_N + RX_FCS_ERR), 0);
        chk("rx gated", rd, 0);
        $display("test reset and gating done");
        rxon = 1;
        apb(1, NET_CTRL_OFS, 32'h0000_0004);
        for (int i = 0; i < CNT_N; i++) begin
            k = $urandom_range(5, 1);
            pulse(i < TX_N, (i < TX_N) ? i : i - TX_N, k);
            apb(0, ca(i), 0);
            chk("counter", rd, DATA_W'(k));
            apb(0, ca(i), 0);
            // Polled well below the narrow counter's maximum
            chk("cleared", rd, 0);
        end
        apb(0, OCT_RX_LO_OFS, 0);
        chk("octets low", rd, DATA_W'(oct));
        apb(0, OCT_RX_HI_OFS, 0);
        chk("octets high", rd, 0);
        $display("test counter bank done");
        apb(1, INT_MASK_OFS, 32'h0000_0003);
        pulse(1, TX_LATE_COL, 20);
        chk("saturation irq", DATA_W'(irq), 1);
        apb(0, ca(TX_LATE_COL), 0);
        chk("saturated", rd, sat(20));
        apb(1, INT_STATUS_OFS, 32'h0000_0003);
        repeat (2) @(posedge mclk_in);
        chk("irq cleared", DATA_W'(irq), 0);
        full <= 1'b1;
        pulse(0, RX_FRAMES, 1);
        chk("drop pulse", DATA_W'(drop), 1);
        full <= 1'b0;
        chk("overflow irq", DATA_W'(irq), 1);
        apb(1, INT_MASK_OFS, 0);
        repeat (2) @(posedge mclk_in);
        chk("irq masked", DATA_W'(irq), 0);
        apb(0, ca(TX_N + RX_OVERRUN), 0);
        chk("overrun", rd, 1);
        $display("test saturation and interrupt done");
        fork
            apb(0, ca(TX_DEFERRED), 0);
            pulse(1, TX_DEFERRED, 3);
        join
        k = int'(rd);
        apb(0, ca(TX_DEFERRED), 0);
        chk("read during event", rd + DATA_W'(k), 3);
        apb(1, NET_CTRL_OFS, 32'h0008_0004);
        repeat (84) @(posedge mclk_in);
        apb(0, LPI_TIME_OFS, 0);
        chk("idle time", rd, 5);
        apb(0, LPI_TIME_OFS, 0);
        chk("idle cleared", rd, 0);
        $display("test coincidence and idle time done");
        final_report();
    end
    initial begin
        #100000;
        bad_count++;
        final_report();
    end
endmodule
